// file: rtl/tft_frame_timing_regs.sv
// Purpose: Frame-timing and nonlinearity-correction register group with
//          sub-frame sequencing, power-down window and capture strobe.
// Assumes: Host port writes and reads whole 24-bit words, one per cycle.
// Notes:   Window outputs follow the sub-frame index one cycle later.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Power-down asserts only outside start..end window.
// - Window end held in bits 23:12.
// - Window start in bits 11:0, resets zero.
// - Averaged sub-frames equal field plus one.
// - Frame holds total field plus one sub-frames.
// - Sub-frame lasts clock count times 25 ns.
// - Capture at 16-bit position, reset 2198h.
// - Reserved capture byte written and read zero.
// - Cubic coefficient upper byte in first word.
// - Cubic coefficient lower byte in second word.
// - Channel zero high offset in first word.
// - Channel one low offset in second word.
module tft_frame_timing_regs
  import tft_pkg::*;
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Host register port
  input wire tft_reg_req_t req_i,
  output logic [23:0] rdata_o,
  output logic rvalid_o,
  // Timing-generator setting held outside this group
  input wire logic [15:0] subframe_clock_count_i,
  // Timing outputs
  output logic powerdown_o,
  output logic averaging_o,
  output logic frame_start_o,
  output logic capture_o,
  output logic [11:0] subframe_index_o,
  // Correction coefficients
  output var tft_coeff_t coeff_o
);

  // ----------------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------------
  logic [23:0] pdn_window;
  logic [23:0] frame_counts;
  logic [15:0] capture_pos;
  logic [23:0] coeff_first;
  logic [23:0] coeff_second;
  logic subframe_end;

  // Write decodes.
  wire wr_window = req_i.wr_en && (req_i.addr == TFT_OFS_PDN_WINDOW);
  wire wr_counts = req_i.wr_en && (req_i.addr == TFT_OFS_FRAME_COUNTS);
  wire wr_capture = req_i.wr_en && (req_i.addr == TFT_OFS_CAPTURE_POS);
  wire wr_first = req_i.wr_en && (req_i.addr == TFT_OFS_COEFF_FIRST);
  wire wr_second = req_i.wr_en && (req_i.addr == TFT_OFS_COEFF_SECOND);

  // Register writes; the reserved capture byte is not stored.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      pdn_window <= TFT_RST_PDN_WINDOW;
      frame_counts <= TFT_RST_FRAME_COUNTS;
      capture_pos <= TFT_RST_CAPTURE_POS;
      coeff_first <= TFT_RST_COEFF;
      coeff_second <= TFT_RST_COEFF;
    end else begin
      if (wr_window) pdn_window <= req_i.wdata;
      if (wr_counts) frame_counts <= req_i.wdata;
      if (wr_capture) capture_pos <= req_i.wdata[TFT_LO16_MSB:0];
      if (wr_first) coeff_first <= req_i.wdata;
      if (wr_second) coeff_second <= req_i.wdata;
    end
  end

  // ----------------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------------
  // Read selection; unmapped addresses return zero.
  wire [23:0] rd_capture = {8'h00, capture_pos};
  wire [23:0] next_rdata =
    (req_i.addr == TFT_OFS_PDN_WINDOW) ? pdn_window :
    (req_i.addr == TFT_OFS_FRAME_COUNTS) ? frame_counts :
    (req_i.addr == TFT_OFS_CAPTURE_POS) ? rd_capture :
    (req_i.addr == TFT_OFS_COEFF_FIRST) ? coeff_first :
    (req_i.addr == TFT_OFS_COEFF_SECOND) ? coeff_second : 24'h000000;

  // Read data appears one cycle after the read strobe and holds.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= 24'h000000;
      rvalid_o <= 1'b0;
    end else begin
      rvalid_o <= req_i.rd_en;
      if (req_i.rd_en) rdata_o <= next_rdata;
    end
  end

  // ----------------------------------------------------------------------
  // Sub-frame sequencing
  // ----------------------------------------------------------------------
  tft_subframe_timer u_timer (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .subframe_clock_count_i(subframe_clock_count_i),
    .capture_clock_position_i(capture_pos),
    .subframe_end_o(subframe_end),
    .capture_o(capture_o)
  );

  // Field views.
  wire [11:0] win_start = pdn_window[TFT_LO12_MSB:TFT_LO12_LSB];
  wire [11:0] win_end = pdn_window[TFT_HI12_MSB:TFT_HI12_LSB];
  wire [11:0] avg_field = frame_counts[TFT_HI12_MSB:TFT_HI12_LSB];
  wire [11:0] total_field = frame_counts[TFT_LO12_MSB:TFT_LO12_LSB];

  // Index wraps after sub-frame number total_field; software keeps the
  // total no smaller than the averaging count, a lower total cuts averaging.
  wire frame_wrap = subframe_end && (subframe_index_o >= total_field);
  wire [11:0] next_index = frame_wrap ? 12'h000
                         : (subframe_end ? subframe_index_o + 12'h001 : subframe_index_o);
  wire outside_window = (subframe_index_o < win_start) || (subframe_index_o > win_end);

  // Sub-frame index and the masks derived from it.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      subframe_index_o <= 12'h000;
      frame_start_o <= 1'b0;
      powerdown_o <= 1'b0;
      averaging_o <= 1'b0;
    end else begin
      subframe_index_o <= next_index;
      frame_start_o <= frame_wrap;
      powerdown_o <= outside_window;
      averaging_o <= (subframe_index_o <= avg_field);
    end
  end

  // Coefficient outputs; the cubic term spans both words.
  // One assignment drives the whole struct, so the port has a single driver.
  assign coeff_o = '{
    cubic_coeff_ch1_low: {coeff_first[TFT_BYTE2_MSB:TFT_BYTE2_LSB],
                          coeff_second[TFT_BYTE2_MSB:TFT_BYTE2_LSB]},
    offset_coeff_ch0_high: coeff_first[TFT_LO16_MSB:0],
    offset_coeff_ch1_low: coeff_second[TFT_LO16_MSB:0]
  };

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  AST_PDN_OUTSIDE: assert property (
    (subframe_index_o < win_start || subframe_index_o > win_end) |=> powerdown_o)
    else $error("Power-down missing outside the window.");
  AST_PDN_INSIDE: assert property (
    (subframe_index_o >= win_start && subframe_index_o <= win_end) |=> !powerdown_o)
    else $error("Power-down asserted inside the window.");
  AST_WIN_END_WRITE: assert property (
    wr_window |=> win_end == $past(req_i.wdata[23:12]) && win_start == $past(req_i.wdata[11:0]))
    else $error("Window fields not stored from write.");
  AST_AVG_MASK: assert property (
    subframe_index_o > avg_field |=> !averaging_o)
    else $error("Averaging beyond the programmed count.");
  AST_FRAME_WRAP: assert property (
    subframe_end && subframe_index_o == total_field |=> subframe_index_o == 12'h000 && frame_start_o)
    else $error("Frame did not wrap after last sub-frame.");
  AST_INDEX_STEP: assert property (
    subframe_end && subframe_index_o < total_field
      |=> subframe_index_o == $past(subframe_index_o) + 12'h001 && !frame_start_o)
    else $error("Sub-frame index failed to advance.");
  AST_RESV_READ_ZERO: assert property (
    req_i.rd_en && req_i.addr == TFT_OFS_CAPTURE_POS |=> rvalid_o && rdata_o[23:16] == 8'h00
      && rdata_o[15:0] == $past(capture_pos))
    else $error("Capture register reserved byte not zero.");
  AST_CUBIC_SPLIT: assert property (
    wr_second |=> coeff_o.cubic_coeff_ch1_low[7:0] == $past(req_i.wdata[23:16]))
    else $error("Cubic low byte not taken from second word.");
  AST_OFFSET_FIRST: assert property (
    wr_first |=> coeff_o.offset_coeff_ch0_high == $past(req_i.wdata[15:0])
      && coeff_o.cubic_coeff_ch1_low[15:8] == $past(req_i.wdata[23:16]))
    else $error("First coefficient word fields wrong.");
  AST_OFFSET_SECOND: assert property (
    wr_second |=> coeff_o.offset_coeff_ch1_low == $past(req_i.wdata[15:0]))
    else $error("Second word offset not stored.");

  // Averaging mask, frame-count storage, index wrap and index hold checks.
  AST_AVG_INSIDE: assert property (
    subframe_index_o <= avg_field |=> averaging_o)
    else $error("Averaging missing within the programmed count.");
  AST_COUNTS_WRITE: assert property (
    wr_counts |=> avg_field == $past(req_i.wdata[23:12])
      && total_field == $past(req_i.wdata[11:0]))
    else $error("Frame count fields not stored from write.");
  AST_WRAP_FROM_ABOVE: assert property (
    subframe_end && subframe_index_o > total_field |=> subframe_index_o == 12'h000)
    else $error("Index beyond a lowered total did not wrap.");
  AST_START_AT_ZERO: assert property (
    frame_start_o |-> subframe_index_o == 12'h000)
    else $error("Frame start pulse away from sub-frame zero.");
  AST_INDEX_HOLD: assert property (
    !subframe_end |=> $stable(subframe_index_o))
    else $error("Sub-frame index moved without a sub-frame end.");

  // Register storage checks: a capture write lands, and nothing else moves the window, capture or coefficient registers.
  AST_CAPTURE_STORE: assert property (
    wr_capture |=> capture_pos == $past(req_i.wdata[15:0]))
    else $error("Capture position not stored from write.");
  AST_WINDOW_HOLD: assert property (
    !wr_window |=> $stable(pdn_window))
    else $error("Window register changed without a write.");
  AST_CAPTURE_HOLD: assert property (
    !wr_capture |=> $stable(capture_pos))
    else $error("Capture register changed without a write.");
  AST_FIRST_HOLD: assert property (
    !wr_first |=> $stable(coeff_first))
    else $error("First coefficient word changed without a write.");
  AST_SECOND_HOLD: assert property (
    !wr_second |=> $stable(coeff_second))
    else $error("Second coefficient word changed without a write.");

  // Main scenarios that the bench is expected to reach.
  COV_FRAME_START: cover property (frame_start_o);
  COV_CAPTURE: cover property (capture_o);
  COV_PDN_ROSE: cover property ($rose(powerdown_o));
  COV_AVG_FELL: cover property ($fell(averaging_o));
  COV_CAPTURE_WRITE: cover property (wr_capture);

endmodule
`default_nettype wire

// file: inc/tft_pkg.sv
// Purpose: Shared constants and types for the frame-timing register group.
// Assumes: Register port carries an 8-bit address and 24-bit data words.
// Notes:   Offsets are the register addresses of the host control port.
package tft_pkg;

  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] TFT_OFS_PDN_WINDOW = 8'h9e;
  localparam logic [7:0] TFT_OFS_FRAME_COUNTS = 8'h9f;
  localparam logic [7:0] TFT_OFS_CAPTURE_POS = 8'ha0;
  localparam logic [7:0] TFT_OFS_COEFF_FIRST = 8'ha2;
  localparam logic [7:0] TFT_OFS_COEFF_SECOND = 8'ha3;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int TFT_HI12_MSB = 23;
  localparam int TFT_HI12_LSB = 12;
  localparam int TFT_LO12_MSB = 11;
  localparam int TFT_LO12_LSB = 0;
  localparam int TFT_LO16_MSB = 15;
  localparam int TFT_BYTE2_MSB = 23;
  localparam int TFT_BYTE2_LSB = 16;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [23:0] TFT_RST_PDN_WINDOW = 24'h000000;
  localparam logic [23:0] TFT_RST_FRAME_COUNTS = 24'h000000;
  localparam logic [15:0] TFT_RST_CAPTURE_POS = 16'h2198;
  localparam logic [23:0] TFT_RST_COEFF = 24'h000000;

  // ----------------------------------------------------------------------
  // Timing: one timing-generator clock is 25 ns, the system clock 5 ns.
  // ----------------------------------------------------------------------
  localparam int TFT_TG_PERIOD_NS = 25;
  localparam int TFT_CLK_PERIOD_NS = 5;
  localparam int TFT_TG_TICK_CYC = TFT_TG_PERIOD_NS / TFT_CLK_PERIOD_NS;
  localparam logic [2:0] TFT_TG_TICK_LAST = 3'(TFT_TG_TICK_CYC - 1);

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic        wr_en;
    logic        rd_en;
    logic [7:0]  addr;
    logic [23:0] wdata;
  } tft_reg_req_t;

  typedef struct packed {
    logic [15:0] cubic_coeff_ch1_low;
    logic [15:0] offset_coeff_ch0_high;
    logic [15:0] offset_coeff_ch1_low;
  } tft_coeff_t;

endpackage

// file: rtl/tft_subframe_timer.sv
// Purpose: Timing-generator clock prescaler and in-sub-frame clock counter.
// Assumes: System clock of 5 ns; a timing-generator clock is 5 system clocks.
// Notes:   A clock count of zero behaves as one so the sub-frame never stalls.
`timescale 1ns/1ps
`default_nettype none
module tft_subframe_timer
  import tft_pkg::*;
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Settings
  input wire logic [15:0] subframe_clock_count_i,
  input wire logic [15:0] capture_clock_position_i,
  // Events
  output logic subframe_end_o,
  output logic capture_o
);

  logic [2:0] presc;
  logic [15:0] tg_cnt;

  // ----------------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------------
  wire tg_tick = (presc == TFT_TG_TICK_LAST);
  wire [15:0] last_cnt = (subframe_clock_count_i == 16'h0000) ? 16'h0000
                         : subframe_clock_count_i - 16'h0001;
  wire at_last = (tg_cnt >= last_cnt);
  wire [2:0] next_presc = tg_tick ? 3'h0 : presc + 3'h1;
  wire [15:0] next_tg_cnt = !tg_tick ? tg_cnt : (at_last ? 16'h0000 : tg_cnt + 16'h0001);

  // Sub-frame lasts the clock count times one 25 ns generator clock.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      presc <= 3'h0;
      tg_cnt <= 16'h0000;
      subframe_end_o <= 1'b0;
      capture_o <= 1'b0;
    end else begin
      presc <= next_presc;
      tg_cnt <= next_tg_cnt;
      subframe_end_o <= tg_tick && at_last;
      capture_o <= tg_tick && (tg_cnt == capture_clock_position_i);
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  AST_SF_MIN_LEN: assert property (@(posedge mclk_i) disable iff (rst_i)
    subframe_end_o |=> !subframe_end_o [*4])
    else $error("Sub-frame shorter than one generator clock.");
  AST_CAPTURE_POS: assert property (@(posedge mclk_i) disable iff (rst_i)
    capture_o |-> $past(tg_cnt) == $past(capture_clock_position_i)
      && $past(presc) == TFT_TG_TICK_LAST)
    else $error("Capture strobe at wrong generator clock count.");

endmodule
`default_nettype wire

// file: verif/tft_frame_timing_regs_tb.sv
// Purpose: Self-checking bench for the frame-timing register group.
// Assumes: Host reads answer one cycle later; outputs are sampled on falling edges.
// Notes:   Each round picks random frame settings and checks the timing outputs.
`timescale 1ns/1ps
`default_nettype none
module tft_frame_timing_regs_tb
  import tft_pkg::*;
;
  // ----------------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------------
  logic mclk_i;
  logic rst_i;
  tft_reg_req_t req_i;
  logic [15:0] sfc;
  logic [23:0] rdata_o;
  logic rvalid_o, powerdown_o, averaging_o, frame_start_o, capture_o;
  logic [11:0] subframe_index_o, tot, avg, ws, we, prev_idx;
  tft_coeff_t coeff_o;
  logic [47:0] expq[$];
  logic [31:0] c1, c2;
  int num_errors = 0;
  int cmp_count = 0;
  int n, cp, cyc, ccnt, nfr;
  bit tmon = 1'b0;
  bit seen = 1'b0;

  tft_frame_timing_regs i_dut (.mclk_i(mclk_i), .rst_i(rst_i), .req_i(req_i),
    .rdata_o(rdata_o), .rvalid_o(rvalid_o), .subframe_clock_count_i(sfc),
    .powerdown_o(powerdown_o), .averaging_o(averaging_o), .frame_start_o(frame_start_o),
    .capture_o(capture_o), .subframe_index_o(subframe_index_o), .coeff_o(coeff_o));

  // Clock of 5 ns period.
  initial begin
    mclk_i = 1'b0;
    forever #2.5 mclk_i = ~mclk_i;
  end

  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  // Compares two values and reports a mismatch at once.
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One host write, held for a single edge.
  task automatic wr(input logic [7:0] a, input logic [23:0] d);
    @(posedge mclk_i);
    req_i <= '{wr_en: 1'b1, rd_en: 1'b0, addr: a, wdata: d};
    @(posedge mclk_i);
    req_i <= '0;
  endtask

  // One host read; the expected word is queued for the read monitor.
  task automatic rd(input logic [7:0] a, input logic [23:0] e);
    @(posedge mclk_i);
    req_i <= '{wr_en: 1'b0, rd_en: 1'b1, addr: a, wdata: 24'h000000};
    expq.push_back(48'(e));
    @(posedge mclk_i);
    req_i <= '0;
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Monitors
  // ----------------------------------------------------------------------
  // Read monitor: each answer takes the oldest queued expectation.
  always @(negedge mclk_i) begin
    if (rvalid_o === 1'b1) begin
      if (expq.size() == 0) begin
        chk(48'(rdata_o), 48'hffffffffffff);
      end else begin
        chk(48'(rdata_o), expq.pop_front());
      end
    end
  end

  // Timing monitor: window levels follow the index one cycle later.
  always @(negedge mclk_i) begin
    if (tmon) begin
      chk(48'(powerdown_o), 48'(prev_idx < ws || prev_idx > we));
      chk(48'(averaging_o), 48'(prev_idx <= avg));
      ccnt = ccnt + int'(capture_o === 1'b1);
      cyc++;
      // First capture of a frame lands one generator clock past its position.
      if (capture_o === 1'b1 && seen && ccnt == 1) begin
        chk(48'(cyc), 48'((cp + 1) * TFT_TG_TICK_CYC - 1));
      end
      if (frame_start_o === 1'b1) begin
        chk(48'(subframe_index_o), 48'h0);
        if (seen) begin
          chk(48'(cyc), 48'((tot + 1) * n * TFT_TG_TICK_CYC));
          chk(48'(ccnt), 48'(tot + 1));
          nfr++;
        end
        seen = 1'b1;
        cyc = 0;
        ccnt = 0;
      end
    end
    prev_idx = subframe_index_o;
  end

  // Watchdog that cuts a hang short.
  initial begin
    #100000;
    num_errors++;
    print_verdict();
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    req_i = '0;
    sfc = 16'h0002;
    rst_i = 1'b1;
    void'($urandom(90829));
    repeat (12) @(posedge mclk_i);
    rst_i <= 1'b0;
    // Reset values, then an unmapped address that reads zero.
    rd(TFT_OFS_PDN_WINDOW, 24'h000000);
    rd(TFT_OFS_FRAME_COUNTS, 24'h000000);
    rd(TFT_OFS_CAPTURE_POS, 24'h002198);
    rd(TFT_OFS_COEFF_FIRST, 24'h000000);
    rd(TFT_OFS_COEFF_SECOND, 24'h000000);
    rd(8'ha1, 24'h000000);
    for (int r = 0; r < 3; r++) begin
      tmon = 1'b0;
      // Software keeps the total at or above the averaging count.
      tot = 12'($urandom_range(5, 1));
      avg = 12'($urandom_range(tot, 0));
      ws = 12'($urandom_range(tot, 0));
      we = 12'($urandom_range(tot, ws));
      n = $urandom_range(3, 1);
      cp = $urandom_range(n - 1, 0);
      c1 = $urandom;
      c2 = $urandom;
      @(posedge mclk_i);
      sfc <= 16'(n);
      wr(TFT_OFS_PDN_WINDOW, {we, ws});
      wr(TFT_OFS_FRAME_COUNTS, {avg, tot});
      wr(TFT_OFS_CAPTURE_POS, {8'h00, 16'(cp)});
      wr(TFT_OFS_COEFF_FIRST, c1[23:0]);
      wr(TFT_OFS_COEFF_SECOND, c2[23:0]);
      rd(TFT_OFS_PDN_WINDOW, {we, ws});
      rd(TFT_OFS_FRAME_COUNTS, {avg, tot});
      rd(TFT_OFS_CAPTURE_POS, {8'h00, 16'(cp)});
      rd(TFT_OFS_COEFF_FIRST, c1[23:0]);
      rd(TFT_OFS_COEFF_SECOND, c2[23:0]);
      @(negedge mclk_i);
      chk(coeff_o, {c1[23:16], c2[23:16], c1[15:0], c2[15:0]});
      // Let the new settings settle, then watch three frames.
      repeat (120) @(posedge mclk_i);
      seen = 1'b0;
      nfr = 0;
      tmon = 1'b1;
      repeat (3 * (tot + 1) * n * TFT_TG_TICK_CYC + 10) @(posedge mclk_i);
      chk(48'(nfr >= 2), 48'h1);
    end
    repeat (4) @(posedge mclk_i);
    chk(48'(expq.size()), 48'h0);
    print_verdict();
  end
endmodule
`default_nettype wire
